// ---- lcd_cmd_host.sv ----
/*
  Host end: AXI4-Lite register slave that sends command codes to the
  LCD controller over the seven-wire link, with a power-on init burst.
  Assumes one clock, aclk at 250 MHz; device samples pins through two
  flip-flops, so each strobe phase lasts several cycles.
*/
`timescale 1ns/1ps
`include "lcd_defines.svh"

module lcd_cmd_host (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq,
  lcd_link_if.host link
);
  lcd_pkg::host_state_t q, d;

  localparam logic [2:0] PHASE_LAST = 3'(`PHASE_CYC - 1);

  // Power-on defaults resent in case the device reset misfired
  function automatic logic [7:0] init_op(input logic [2:0] i);
    case (i)
      3'h0: init_op = `OP_BIAS_FIFTH;
      3'h1: init_op = `OP_SLOW_REFRESH;
      3'h2: init_op = {`OP_INTERVAL_TOP, `RST_INTERVAL};
      default: init_op = `OP_NORMAL;
    endcase
  endfunction

  // Offsets past the map fold onto a hole, never onto the command word
  function automatic logic [3:0] reg_sel(input logic [31:0] a);
    reg_sel = (a[31:4] == 28'h0000000) ? a[3:0] : 4'hf;
  endfunction

  function automatic lcd_pkg::host_state_t launch(input lcd_pkg::host_state_t s,
                                                 input logic [7:0] op,
                                                 input logic chain);
    lcd_pkg::host_state_t r;
    r = s;
    r.tmr = 3'h0;
    if (chain && s.live) begin
      r.sh = {op, 8'h00}; // R2
      r.cnt = 3'h3;
      r.st = lcd_pkg::H_WRLO;
      r.wr_n = 1'b0;
      r.db_o = op[7:4];
      r.db_oe = 1'b1;
    end else begin
      r.sh = {`ID_NIBBLE, op, 4'h0}; // R1
      r.cnt = 3'h4;
      r.cs_n = 1'b1; // R15
      r.st = lcd_pkg::H_CSHI;
    end
    return r;
  endfunction

  always_comb begin
    d = q;
    // AXI write: address and data taken in either order
    if (s_axi_awvalid && q.awready) begin
      d.aw_have = 1'b1;
      d.awaddr = reg_sel(s_axi_awaddr);
    end
    if (s_axi_wvalid && q.wready) begin
      d.w_have = 1'b1;
      d.wdata = s_axi_wdata[8:0];
    end
    if (s_axi_bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (q.aw_have && q.w_have && !q.bvalid) begin
      d.aw_have = 1'b0;
      d.w_have = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = `RESP_OKAY;
      if (q.awaddr == `REG_CMD) begin
        if (q.pend || q.st != lcd_pkg::H_IDLE || q.wdata[7:0] == `OP_TEST) begin
          d.irq_stat[`IRQ_REFUSED] = 1'b1; // R11
        end else begin
          d.pend = 1'b1;
          d.pop = q.wdata[7:0];
          d.pchain = q.wdata[`CMD_CHAIN_BIT];
        end
      end else if (q.awaddr == `REG_IRQ_STAT) begin
        d.irq_stat = q.irq_stat & ~q.wdata[1:0];
      end else if (q.awaddr == `REG_IRQ_MASK) begin
        d.irq_mask = q.wdata[1:0];
      end else if (q.awaddr != `REG_STATUS) begin
        d.bresp = `RESP_SLVERR;
      end
    end
    d.awready = !d.aw_have;
    d.wready = !d.w_have;

    // AXI read
    if (s_axi_rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && q.arready) begin
      d.rvalid = 1'b1;
      d.rresp = `RESP_OKAY;
      d.rdata = 32'h00000000;
      if (reg_sel(s_axi_araddr) == `REG_STATUS) begin
        d.rdata[0] = q.pend || q.st != lcd_pkg::H_IDLE;
        d.rdata[1] = q.init_idx == `INIT_COUNT;
      end else if (reg_sel(s_axi_araddr) == `REG_IRQ_STAT) begin
        d.rdata[1:0] = q.irq_stat;
      end else if (reg_sel(s_axi_araddr) == `REG_IRQ_MASK) begin
        d.rdata[1:0] = q.irq_mask;
      end else if (reg_sel(s_axi_araddr) != `REG_CMD) begin
        d.rresp = `RESP_SLVERR;
      end
    end
    d.arready = !d.rvalid;

    // Link sequencer
    d.tmr = q.tmr + 3'h1;
    case (q.st)
      lcd_pkg::H_IDLE: begin
        d.tmr = 3'h0;
        if (q.init_idx != `INIT_COUNT) begin
          d = launch(d, init_op(q.init_idx), q.init_idx != 3'h0); // R14
          d.init_idx = q.init_idx + 3'h1;
        end else if (q.pend) begin
          d = launch(d, q.pop, q.pchain);
          d.pend = 1'b0;
        end
      end
      lcd_pkg::H_CSHI: begin
        if (q.tmr == PHASE_LAST) begin
          d.tmr = 3'h0;
          d.cs_n = 1'b0;
          d.live = 1'b1;
          d.wr_n = 1'b0;
          d.db_o = q.sh[15:12];
          d.db_oe = 1'b1;
          d.st = lcd_pkg::H_WRLO;
        end
      end
      lcd_pkg::H_WRLO: begin
        if (q.tmr == PHASE_LAST) begin
          d.tmr = 3'h0;
          d.wr_n = 1'b1; // R16
          d.st = lcd_pkg::H_WRHI;
        end
      end
      default: begin
        if (q.tmr == PHASE_LAST) begin
          d.tmr = 3'h0;
          d.sh = {q.sh[11:0], 4'h0};
          d.cnt = q.cnt - 3'h1;
          if (q.cnt == 3'h1) begin
            d.db_oe = 1'b0;
            d.st = lcd_pkg::H_IDLE;
            d.irq_stat[`IRQ_DONE] = 1'b1;
          end else begin
            d.wr_n = 1'b0;
            d.db_o = q.sh[11:8];
            d.st = lcd_pkg::H_WRLO;
          end
        end
      end
    endcase
    d.irq = |(d.irq_stat & d.irq_mask);

    if (!aresetn) begin
      d = '0;
      d.st = lcd_pkg::H_IDLE;
      d.cs_n = 1'b1;
      d.wr_n = 1'b1;
      d.rd_n = 1'b1;
      d.awready = 1'b1;
      d.wready = 1'b1;
      d.arready = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    q <= d;
  end

  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign irq = q.irq;
  assign link.cs_n = q.cs_n;
  assign link.wr_n = q.wr_n;
  assign link.rd_n = q.rd_n;
  assign link.db_host_o = q.db_o;
  assign link.db_host_oe = q.db_oe;
endmodule

// ---- lcd_defines.svh ----
/*
  Shared constants of the LCD command link: mode identifiers, command
  codes, reset values, timing and the host register map.
  Assumes inclusion by bare name from every file that needs them.
*/
`ifndef LCD_DEFINES_SVH
`define LCD_DEFINES_SVH
`define ID_READ 3'h6
`define ID_WRITE 3'h5
`define ID_CMD 3'h4
`define ID_NIBBLE 4'h4
`define OP_SMALL_BIAS 8'h18
`define OP_BIAS_FIFTH 8'h19
`define OP_BIAS_QUARTER 8'h1a
`define OP_FAST_REFRESH 8'h1c
`define OP_SLOW_REFRESH 8'h1d
`define OP_INTERVAL_TOP 5'h14
`define OP_TEST 8'hff
`define OP_NORMAL 8'hfe
`define SHADE_TOP_MIN 3'h1
`define SHADE_TOP_MAX 3'h4
`define SECTIONS_FAST 5'h0d
`define SECTIONS_SLOW 5'h18
`define RST_INTERVAL 3'h7
`define RST_SHADE 5'h00
`define SRC_HZ 32768
`define ACLK_HZ 250000000
`define ACLK_MHZ 250
`define TICK_DIV (`ACLK_HZ / `SRC_HZ)
`define WDT_FULL 17'h1ffff
`define TB_TOP 4'he
`define PHASE_NS 16
`define PHASE_CYC (((`PHASE_NS * `ACLK_MHZ) + 999) / 1000)
`define INIT_COUNT 3'h4
`define REG_CMD 4'h0
`define REG_STATUS 4'h4
`define REG_IRQ_STAT 4'h8
`define REG_IRQ_MASK 4'hc
`define CMD_CHAIN_BIT 8
`define IRQ_DONE 0
`define IRQ_REFUSED 1
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ---- lcd_pkg.sv ----
/*
  Types of the LCD command link: state machines and the state records
  of both ends.
  Assumes the constants header is compiled alongside.
*/
package lcd_pkg;
  typedef enum logic [2:0] {ST_ID, ST_HI, ST_LO, ST_PAD, ST_DATA} link_st_t;
  typedef enum logic [1:0] {H_IDLE, H_CSHI, H_WRLO, H_WRHI} host_st_t;

  typedef struct packed {
    logic cs_s1;
    logic cs_s2;
    logic wr_s1;
    logic wr_s2;
    logic wr_p;
    logic [3:0] db_s1;
    logic [3:0] db_s2;
    link_st_t st;
    logic [3:0] cmd_hi;
    logic bias_small;
    logic bias_quarter;
    logic fast;
    logic slow;
    logic [4:0] sections;
    logic [3:0][4:0] shade;
    logic [2:0] interval;
    logic test_mode;
    logic [12:0] div;
    logic [16:0] tb_cnt;
    logic tb_out;
    logic wdt_pulse;
    logic cmd_pulse;
    logic [3:0] db_o;
    logic db_oe;
  } dev_state_t;

  typedef struct packed {
    host_st_t st;
    logic [2:0] tmr;
    logic [15:0] sh;
    logic [2:0] cnt;
    logic live;
    logic [2:0] init_idx;
    logic pend;
    logic [7:0] pop;
    logic pchain;
    logic cs_n;
    logic wr_n;
    logic rd_n;
    logic [3:0] db_o;
    logic db_oe;
    logic aw_have;
    logic [3:0] awaddr;
    logic w_have;
    logic [8:0] wdata;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic irq;
  } host_state_t;
endpackage

// ---- lcd_link_if.sv ----
/*
  Seven-wire parallel link between host and LCD controller.
  Assumes the bench ties the wires of both modports; the data bus level
  is resolved here from the two output enables, idle high.
*/
`timescale 1ns/1ps
interface lcd_link_if;
  logic cs_n;
  logic wr_n;
  logic rd_n;
  logic [3:0] db_host_o;
  logic db_host_oe;
  logic [3:0] db_dev_o;
  logic db_dev_oe;
  logic [3:0] db;

  // Pulled high when nobody drives
  assign db = db_host_oe ? db_host_o : (db_dev_oe ? db_dev_o : 4'hf);

  modport device (input cs_n, input wr_n, input rd_n, input db,
                  output db_dev_o, output db_dev_oe);
  modport host (output cs_n, output wr_n, output rd_n, output db_host_o,
                output db_host_oe, input db);
endinterface

// ---- lcd_cmd_device.sv ----
/*
  Device end: decodes command-mode instructions arriving on the
  seven-wire link and holds the display configuration.
  Assumes aclk runs at 250 MHz and that all link pins are asynchronous
  to it; cs_n, wr_n and db pass two flip-flops first, rd_n is not used.
*/
`timescale 1ns/1ps
`include "lcd_defines.svh"

// Contract
// [R1] Mode ID 110 read, 101 write, 100 command
// [R2] Chained commands omit the repeated mode ID
// [R3] Lead bit and trailing nibble are ignored
// [R4] Code 18 selects small bias current
// [R5] Codes 19/1a pick 1/5 or 1/4 bias
// [R6] Code 1c: 170 Hz, 13 sections
// [R7] Code 1d: 89 Hz, 24 sections
// [R8] Top bits 001..100 load shade widths
// [R9] Codes a0..a7 pick time base 1..128 Hz
// [R10] Same codes pick watchdog 4 s..1/32 s
// [R11] Host never sends code ff
// [R12] Reset: 1/5 bias, 89 Hz, 128 Hz, normal
// [R13] Time base derived from 32 kHz source
// [R14] Host re-initialises configuration after power-on
// [R15] Chip select high aborts and re-initialises
// [R16] Nibbles sampled on write strobe rising edge
// [R17] Unknown codes change no configuration
module lcd_cmd_device #(
  parameter int unsigned TICK_DIV = `TICK_DIV
) (
  input wire logic aclk,
  input wire logic aresetn,
  lcd_link_if.device link,
  output logic bias_small,
  output logic bias_quarter,
  output logic fast_refresh_select,
  output logic slow_refresh_select,
  output logic [4:0] pwm_sections,
  output logic [4:0] shade_one_width,
  output logic [4:0] shade_two_width,
  output logic [4:0] shade_three_width,
  output logic [4:0] shade_four_width,
  output logic [2:0] interval_code,
  output logic test_mode,
  output logic time_base_out,
  output logic watchdog_timeout,
  output logic cmd_strobe
);
  lcd_pkg::dev_state_t q, d;

  localparam logic [12:0] DIV_LAST = 13'(TICK_DIV - 1);

  // Watchdog stage length shrinks by half per interval step
  function automatic logic [16:0] wdt_mask(input logic [2:0] code);
    wdt_mask = `WDT_FULL >> code;
  endfunction

  function automatic logic [3:0] tb_bit(input logic [2:0] code);
    tb_bit = `TB_TOP - {1'b0, code};
  endfunction

  // Applies one 8-bit command code to the configuration in s
  function automatic lcd_pkg::dev_state_t apply(input lcd_pkg::dev_state_t s,
                                                input logic [7:0] op);
    lcd_pkg::dev_state_t r;
    logic [2:0] lvl;
    r = s;
    lvl = op[7:5] - `SHADE_TOP_MIN;
    if (op == `OP_SMALL_BIAS) begin
      r.bias_small = 1'b1; // R4
    end else if (op == `OP_BIAS_FIFTH) begin
      r.bias_quarter = 1'b0; // R5
    end else if (op == `OP_BIAS_QUARTER) begin
      r.bias_quarter = 1'b1; // R5
    end else if (op == `OP_FAST_REFRESH) begin
      r.fast = 1'b1; // R6
      r.slow = 1'b0;
      r.sections = `SECTIONS_FAST; // R6
    end else if (op == `OP_SLOW_REFRESH) begin
      r.fast = 1'b0; // R7
      r.slow = 1'b1;
      r.sections = `SECTIONS_SLOW; // R7
    end else if (op[7:5] >= `SHADE_TOP_MIN && op[7:5] <= `SHADE_TOP_MAX) begin
      r.shade[lvl[1:0]] = op[4:0]; // R8
    end else if (op[7:3] == `OP_INTERVAL_TOP) begin
      r.interval = op[2:0]; // R9 R10
    end else if (op == `OP_NORMAL) begin
      r.test_mode = 1'b0;
    end else if (op == `OP_TEST) begin
      // Kept visible so a stray factory code can be spotted
      r.test_mode = 1'b1;
    end
    // Any other code falls through untouched R17
    return r;
  endfunction

  always_comb begin
    d = q;
    d.cs_s1 = link.cs_n;
    d.cs_s2 = q.cs_s1;
    d.wr_s1 = link.wr_n;
    d.wr_s2 = q.wr_s1;
    d.wr_p = q.wr_s2;
    d.db_s1 = link.db;
    d.db_s2 = q.db_s1;
    d.cmd_pulse = 1'b0;
    d.wdt_pulse = 1'b0;
    // Reads of display memory are out of scope, bus stays released
    d.db_o = 4'h0;
    d.db_oe = 1'b0;

    if (q.cs_s2) begin
      d.st = lcd_pkg::ST_ID; // R15
    end else if (q.wr_s2 && !q.wr_p) begin // R16
      case (q.st)
        lcd_pkg::ST_ID: begin
          // Top bit of the first nibble is a don't-care R3
          if (q.db_s2[2:0] == `ID_CMD) begin // R1
            d.st = lcd_pkg::ST_HI;
          end else begin
            // Read and write frames are swallowed until deselect R1
            d.st = lcd_pkg::ST_DATA;
          end
        end
        lcd_pkg::ST_HI: begin
          d.cmd_hi = q.db_s2;
          d.st = lcd_pkg::ST_LO;
        end
        lcd_pkg::ST_LO: begin
          d = apply(d, {q.cmd_hi, q.db_s2});
          d.cmd_pulse = 1'b1;
          d.st = lcd_pkg::ST_PAD;
        end
        lcd_pkg::ST_PAD: begin
          // Trailing nibble ignored; next word needs no ID R2 R3
          d.st = lcd_pkg::ST_HI;
        end
        default: begin
          d.st = lcd_pkg::ST_DATA;
        end
      endcase
    end

    // 32 kHz source tick made from aclk R13
    if (q.div == DIV_LAST) begin
      d.div = 13'h0000;
      d.tb_cnt = q.tb_cnt + 17'h00001;
      if ((q.tb_cnt & wdt_mask(q.interval)) == wdt_mask(q.interval)) begin
        d.wdt_pulse = 1'b1; // R10
      end
    end else begin
      d.div = q.div + 13'h0001;
    end
    d.tb_out = q.tb_cnt[tb_bit(q.interval)]; // R9 R13

    if (!aresetn) begin
      d = '0;
      d.cs_s1 = 1'b1;
      d.cs_s2 = 1'b1;
      d.wr_s1 = 1'b1;
      d.wr_s2 = 1'b1;
      d.wr_p = 1'b1;
      d.st = lcd_pkg::ST_ID;
      d.bias_quarter = 1'b0; // R12
      d.fast = 1'b0; // R12
      d.slow = 1'b1;
      d.sections = `SECTIONS_SLOW;
      d.shade = {4{`RST_SHADE}};
      d.interval = `RST_INTERVAL; // R12
      d.test_mode = 1'b0; // R12
    end
  end

  always_ff @(posedge aclk) begin
    q <= d;
  end

  assign link.db_dev_o = q.db_o;
  assign link.db_dev_oe = q.db_oe;
  assign bias_small = q.bias_small;
  assign bias_quarter = q.bias_quarter;
  assign fast_refresh_select = q.fast;
  assign slow_refresh_select = q.slow;
  assign pwm_sections = q.sections;
  assign shade_one_width = q.shade[0];
  assign shade_two_width = q.shade[1];
  assign shade_three_width = q.shade[2];
  assign shade_four_width = q.shade[3];
  assign interval_code = q.interval;
  assign test_mode = q.test_mode;
  assign time_base_out = q.tb_out;
  assign watchdog_timeout = q.wdt_pulse;
  assign cmd_strobe = q.cmd_pulse;
endmodule

// ---- lcd_cmd_device_end.sv ----
/*
  Holds no code: the device end is described in lcd_cmd_device.sv.
  Assumes nothing of its surroundings.
*/

// ---- lcd_link_monitor.sv ----
/*
  Checker of the host-device link and the device configuration outputs.
  Assumes one clock domain; the bench instantiates it beside the link.
*/
`timescale 1ns/1ps
module lcd_link_monitor #(
  parameter int unsigned TICK_DIV = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic cs_n,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic db_host_oe,
  input wire logic db_dev_oe,
  input wire logic [3:0] db,
  input wire logic fast_refresh_select,
  input wire logic slow_refresh_select,
  input wire logic [4:0] pwm_sections,
  input wire logic [2:0] interval_code,
  input wire logic watchdog_timeout,
  input wire logic cmd_strobe
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Fastest watchdog interval: 1/32 s of 32768 Hz ticks
  localparam int unsigned WDT7 = 1024 * TICK_DIV;
  logic [31:0] gap_q;
  logic [2:0] code_q;
  logic armed_q;
  // Disarm on any command: a re-sent interval may restart the count
  always_ff @(posedge aclk) begin
    code_q <= interval_code;
    gap_q <= (!aresetn || watchdog_timeout) ? 32'h0 : gap_q + 32'h1;
    if (!aresetn || cmd_strobe || code_q != interval_code) begin
      armed_q <= 1'b0;
    end else if (watchdog_timeout) begin
      armed_q <= 1'b1;
    end
  end
  sequence s_wr_phase;
    (!wr_n) [*4] ##1 wr_n;
  endsequence
  a_wr_phase: assert property ($fell(wr_n) |-> s_wr_phase)
    else $error("write strobe low phase not four cycles");
  a_db_held: assert property ($rose(wr_n) |-> db == $past(db, 4))
    else $error("data changed while strobe low");
  a_db_driven: assert property (!wr_n |-> db_host_oe)
    else $error("strobe low with data not driven");
  a_wr_in_cs: assert property (!wr_n |-> !cs_n)
    else $error("write strobe outside chip select");
  a_cs_pulse: assert property ($fell(cs_n) |-> $past(cs_n, 4))
    else $error("chip select high pulse too short");
  a_id_first: assert property ($fell(cs_n) |-> !wr_n && db[2:0] == 3'h4)
    else $error("frame does not open with command mode id");
  a_rd_idle: assert property (rd_n && !db_dev_oe)
    else $error("read strobe or device drive seen");
  a_fast_sections: assert property (fast_refresh_select |-> pwm_sections == 5'h0d)
    else $error("fast refresh without 13 sections");
  a_slow_sections: assert property (slow_refresh_select |-> pwm_sections == 5'h18)
    else $error("slow refresh without 24 sections");
  a_one_refresh: assert property (fast_refresh_select ^ slow_refresh_select)
    else $error("refresh selects not exclusive");
  a_strobe_single: assert property (cmd_strobe |=> !cmd_strobe)
    else $error("command strobe longer than one cycle");
  a_wdt_period: assert property (watchdog_timeout && armed_q && code_q == interval_code
    && interval_code == 3'h7 |-> gap_q == WDT7 - 1)
    else $error("watchdog period wrong for fastest interval");
  c_strobe: cover property (cmd_strobe);
endmodule

// ---- lcd_command_decoder_tb_top.sv ----
/*
  Bench of the command link: AXI host, device, and a second device fed
  faulty frames directly; outputs compared with a model.
  Assumes design files and checker are compiled first.
*/
`timescale 1ns/1ps
`include "lcd_defines.svh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin failures++; \
  $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module lcd_command_decoder_tb_top;
  localparam int TD = 4;
  logic aclk = 0, aresetn = 0;
  logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp;
  logic bs, bq, fr, sr, tm, tb, wd, stb, fr_b;
  logic [4:0] sec, sh1, sh2, sh3, sh4, sec_b;
  logic [2:0] ic;
  int failures = 0, checks = 0, cyc = 0;
  int m_bs = 0, m_bq = 0, m_fast = 0, m_ic = 7, m_tm = 0;
  int m_sh[4] = '{0, 0, 0, 0};
  lcd_link_if link();
  lcd_link_if link_b();
  always #2 aclk = ~aclk;
  lcd_cmd_host i_lcd_cmd_host (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .irq(irq), .link(link.host));
  lcd_cmd_device #(.TICK_DIV(TD)) i_lcd_cmd_device (.aclk(aclk), .aresetn(aresetn),
    .link(link.device), .bias_small(bs), .bias_quarter(bq), .fast_refresh_select(fr),
    .slow_refresh_select(sr), .pwm_sections(sec), .shade_one_width(sh1),
    .shade_two_width(sh2), .shade_three_width(sh3), .shade_four_width(sh4),
    .interval_code(ic), .test_mode(tm), .time_base_out(tb), .watchdog_timeout(wd),
    .cmd_strobe(stb));
  lcd_cmd_device #(.TICK_DIV(TD)) i_lcd_cmd_device_b (.aclk(aclk), .aresetn(aresetn),
    .link(link_b.device), .bias_small(), .bias_quarter(), .fast_refresh_select(fr_b),
    .slow_refresh_select(), .pwm_sections(sec_b), .shade_one_width(),
    .shade_two_width(), .shade_three_width(), .shade_four_width(), .interval_code(),
    .test_mode(), .time_base_out(), .watchdog_timeout(), .cmd_strobe());
  lcd_link_monitor #(.TICK_DIV(TD)) i_lcd_link_monitor (.aclk(aclk), .aresetn(aresetn),
    .cs_n(link.cs_n), .wr_n(link.wr_n), .rd_n(link.rd_n), .db_host_oe(link.db_host_oe),
    .db_dev_oe(link.db_dev_oe), .db(link.db), .fast_refresh_select(fr),
    .slow_refresh_select(sr), .pwm_sections(sec), .interval_code(ic),
    .watchdog_timeout(wd), .cmd_strobe(stb));
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Covers init burst, all commands, timer measurements and fault frames
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 90000) begin
      failures++;
      summarize();
    end
  end
  function automatic void apply(int c);
    if (c == 'h18) m_bs = 1;
    else if (c == 'h19 || c == 'h1a) m_bq = (c == 'h1a);
    else if (c == 'h1c || c == 'h1d) m_fast = (c == 'h1c);
    else if (c >= 'h20 && c < 'ha0) m_sh[(c >> 5) - 1] = c & 31;
    else if ((c >> 3) == 'h14) m_ic = c & 7;
    else if (c == 'hfe) m_tm = 0;
  endfunction
  task automatic cmp();
    `CHK("bias_small", m_bs, bs)
    `CHK("bias_quarter", m_bq, bq)
    `CHK("fast_refresh", m_fast, fr)
    `CHK("slow_refresh", 1 - m_fast, sr)
    `CHK("pwm_sections", m_fast ? 13 : 24, sec)
    `CHK("shade_one", m_sh[0], sh1)
    `CHK("shade_two", m_sh[1], sh2)
    `CHK("shade_three", m_sh[2], sh3)
    `CHK("shade_four", m_sh[3], sh4)
    `CHK("interval", m_ic, ic)
    `CHK("test_mode", m_tm, tm)
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!bvalid);
    bready <= 0;
    r = bresp;
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 0;
    end while (!rvalid);
    rready <= 0;
    d = rdata;
    r = rresp;
  endtask
  task automatic send(input int c);
    logic [31:0] d;
    logic [1:0] r;
    // Random chain bit exercises both framings
    wr(`REG_CMD, {23'h0, 1'($urandom), c[7:0]}, r);
    `CHK("cmd_resp", `RESP_OKAY, r)
    d = 1;
    while (d[0]) rd(`REG_STATUS, d, r);
    apply(c);
    cmp();
    `CHK("irq_done", 1'b1, irq)
    wr(`REG_IRQ_STAT, 32'h3, r);
    repeat (2) @(posedge aclk);
    `CHK("irq_clear", 1'b0, irq)
  endtask
  task automatic meas(input bit w, input int exp);
    int k, n;
    logic p, s;
    k = 0;
    n = 0;
    p = w ? wd : tb;
    while (k < 2 && n < 40000) begin
      @(posedge aclk);
      s = w ? wd : tb;
      if (s && !p) k++;
      if (k == 1) n++;
      p = s;
    end
    `CHK(w ? "wdt_period" : "tb_period", exp, n)
  endtask
  task automatic csp(input logic v);
    @(posedge aclk);
    link_b.cs_n <= v;
    repeat (`PHASE_CYC) @(posedge aclk);
  endtask
  task automatic nib(input logic [3:0] v);
    @(posedge aclk);
    link_b.wr_n <= 0;
    link_b.db_host_o <= v;
    link_b.db_host_oe <= 1;
    repeat (`PHASE_CYC) @(posedge aclk);
    link_b.wr_n <= 1;
    repeat (`PHASE_CYC - 1) @(posedge aclk);
  endtask
  // Negative id sends a chained word with no mode id
  task automatic frame(input int id, input logic [7:0] op, input logic [3:0] pad);
    if (id >= 0) begin
      csp(1);
      csp(0);
      nib(id[3:0]);
    end
    nib(op[7:4]);
    nib(op[3:0]);
    nib(pad);
    repeat (8) @(posedge aclk);
  endtask
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    int codes[$] = '{'h18, 'h1a, 'h19, 'h1c, 'h1b, 'hc3, 'h1d, 'hfe};
    link_b.cs_n = 1;
    link_b.wr_n = 1;
    link_b.rd_n = 1;
    link_b.db_host_o = 0;
    link_b.db_host_oe = 0;
    void'($urandom(32'h9081));
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    cmp();
    d = 0;
    while (!d[1]) rd(`REG_STATUS, d, r);
    // Done flag rises while the last init word is still on the link
    while (d[0]) rd(`REG_STATUS, d, r);
    `CHK("init_done", 2'h2, d[1:0])
    cmp();
    wr(`REG_IRQ_STAT, 32'h3, r);
    wr(`REG_IRQ_MASK, 32'h3, r);
    foreach (codes[i]) send(codes[i]);
    for (int t = 1; t <= 4; t++) send(t * 32 + ($urandom % 32));
    for (int k = 0; k < 8; k++) send('ha0 + k);
    meas(0, 256 * TD);
    meas(1, 1024 * TD);
    send('ha4);
    meas(0, 2048 * TD);
    wr(`REG_CMD, 32'hff, r);
    `CHK("test_resp", `RESP_OKAY, r)
    rd(`REG_IRQ_STAT, d, r);
    `CHK("refused", 2'h2, d[1:0])
    repeat (2) @(posedge aclk);
    `CHK("irq_refused", 1'b1, irq)
    wr(`REG_IRQ_MASK, 32'h0, r);
    repeat (2) @(posedge aclk);
    `CHK("irq_masked", 1'b0, irq)
    wr(32'h10, 32'h1c, r);
    `CHK("unmapped_wr", `RESP_SLVERR, r)
    rd(32'h10, d, r);
    `CHK("unmapped_rd", `RESP_SLVERR, r)
    cmp();
    frame(5, 8'h1c, 4'h0);
    `CHK("wrong_id", 1'b0, fr_b)
    frame(4'hc, 8'h1c, 4'hf);
    `CHK("loose_bits", 1'b1, fr_b)
    `CHK("sections_b", 5'h0d, sec_b)
    frame(-1, 8'h1d, 4'h0);
    `CHK("chained", 1'b0, fr_b)
    nib(4'h1);
    csp(1);
    csp(0);
    // Without the abort this nibble would complete code 1c
    nib(4'hc);
    repeat (8) @(posedge aclk);
    `CHK("aborted", 1'b0, fr_b)
    summarize();
  end
endmodule
